//--- hdl/rffe_switch_defines.svh
// Purpose: Register offsets, field positions and codes of the switch slave
// Assumes: Included by bare name from the design file
// Notes:   Register field ranges are macros; frame fields in the logic stay as bare positions
`ifndef RFFE_SWITCH_DEFINES_SVH
`define RFFE_SWITCH_DEFINES_SVH

// Register offsets
`define A_SW      8'h00
`define A_PM      8'h1c
`define A_PID     8'h1d
`define A_MID     8'h1e
`define A_MUS     8'h1f
`define A_EPID    8'h20
`define A_REV     8'h21
`define A_GRP     8'h22
`define A_SWR     8'h23
`define A_ERR     8'h24
`define A_BHV     8'h2b

// Reset values
`define SW_RST    8'h00
`define PM_RST    8'h80
`define UNIQUE_SLAVE_ID_RST  4'h8
`define GROUP_SLAVE_ID_RST  4'h0
`define ERR_RST   8'h00
`define TEN_RST   1'b1

// Field positions
`define PM_MODE   7
`define PM_PRST   6
`define PM_MASK_F 5:3
`define PM_MASK0  3
`define PM_TRIG0  0
`define UNIQUE_SLAVE_ID_F    3:0
`define GROUP_SLAVE_ID_F    7:4
`define SWR_BIT   7
`define BHV_TEN   0
`define E_CPAR    6
`define E_LEN     5
`define E_APAR    4
`define E_DPAR    3
`define E_RD      2
`define E_WR      1

// Frame layout: last bit index of a command frame and of a byte frame
`define CMD_LAST  4'd12
`define FRM_LAST  4'd8
`define BCAST_ID  4'h0

// Command codes
`define CMD_REGW  3'b010
`define CMD_REGR  3'b011
`define CMD_EXTW  4'h0
`define CMD_EXTR  4'h2

`endif

//--- hdl/rffe_switch_pkg.sv
// Purpose: Types of the switch control slave
// Assumes: Constants live in rffe_switch_defines.svh
// Notes:   Link and core state each travel as one packed struct
package rffe_switch_pkg;

    // Link sequencer, Gray along the usual path
    typedef enum logic [2:0] {
        PH_IDLE  = 3'b000,
        PH_CMD   = 3'b001,
        PH_ADDR  = 3'b011,
        PH_DATA  = 3'b010,
        PH_PARK  = 3'b110,
        PH_RPARK = 3'b111,
        PH_RDATA = 3'b101
    } phase_t;

    typedef enum logic [1:0] {
        PS_STARTUP = 2'b00,
        PS_ACTIVE  = 2'b01,
        PS_LOW     = 2'b11
    } power_state_t;

    // Start-mark watcher in the core domain
    typedef enum logic [1:0] {
        W_IDLE = 2'b00,
        W_WAIT = 2'b01,
        W_RUN  = 2'b11
    } watch_t;

    // Word handed from link to core
    typedef struct packed {
        logic       pr_tog;
        logic       low_power;
        logic [7:0] sw;
    } xfer_t;

    typedef struct packed {
        logic        tg_a, tg_b, tg_c;
        logic        rs_a, rs_b;
        logic        v2_a, v2_b;
        logic [1:0]  hist;
        phase_t      ph;
        logic [3:0]  cnt;
        logic [12:0] sh;
        logic [3:0]  sa;
        logic        rd;
        logic [7:0]  addr;
        logic [3:0]  left;
        logic [8:0]  rdat;
        logic        sdo, oe, busy;
        logic [7:0]  sw_sh, sw_act, pm, err;
        logic [3:0]  unique_slave_id, group_slave_id;
        logic        trig_en, pr_tog;
        xfer_t       hold;
        logic        htog;
    } link_t;

    typedef struct packed {
        logic         sd_a, sd_b, sd_c;
        logic         bz_a, bz_b;
        logic         ht_a, ht_b, ht_c;
        logic         ssc_tog;
        watch_t       watch;
        xfer_t        cur;
        logic         pr_seen, pr_run;
        power_state_t pst;
    } core_t;

endpackage

//--- hdl/rffe_switch_control_slave.sv
// Purpose: Slave control logic of an RF switch on the two-wire front-end bus
// Assumes: Link logic samples the data pin on falling i_sclk edges
// Notes:   Start marks are seen in the i_clk domain and handed over by toggle
`timescale 1ns/1ps
`include "rffe_switch_defines.svh"
module rffe_switch_control_slave #(
    parameter logic [7:0] ID_PRODUCT = 8'h5a, // Arbitrary value
    parameter logic [7:0] ID_MAKER   = 8'h33, // Arbitrary value
    parameter logic [1:0] ID_MAKER_H = 2'b10, // Arbitrary value
    parameter logic [7:0] ID_EXT     = 8'h11, // Arbitrary value
    parameter logic [7:0] ID_REV     = 8'h21  // Arbitrary value
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_resetn,
    input  wire logic                          i_ce,
    input  wire logic                          i_sclk,
    input  wire logic                          i_sdata,
    input  wire logic                          i_proto_v2,
    output rffe_switch_pkg::power_state_t      o_power_state,
    output logic [7:0]                         o_switch_state,
    output logic                               o_sdata,
    output logic                               o_sdata_oe
);
    import rffe_switch_pkg::*;

    link_t lq;
    link_t ln;
    core_t cq;
    core_t cn;

    // Defaults of the switch-side registers
    function automatic link_t user_defaults(input link_t s);
        link_t r;
        r = s;
        r.sw_sh = `SW_RST;
        r.sw_act = `SW_RST;
        r.trig_en = `TEN_RST;
        return r;
    endfunction

    // Read decode: {implemented, value}
    function automatic logic [8:0] reg_read(input link_t s, input logic [7:0] a);
        logic [8:0] v;
        v = 9'h000;
        case (a)
            `A_SW:   v = {1'b1, s.sw_act};
            `A_PM:   v = {1'b1, s.pm};
            `A_PID:  v = {1'b1, ID_PRODUCT};
            `A_MID:  v = {1'b1, ID_MAKER};
            `A_MUS:  v = {1'b1, 2'b00, ID_MAKER_H, s.unique_slave_id};
            `A_EPID: v = {1'b1, ID_EXT};
            `A_REV:  v = {1'b1, ID_REV};
            `A_GRP:  v = {1'b1, s.group_slave_id, 4'h0};
            `A_SWR:  v = {1'b1, 8'h00};
            `A_ERR:  v = {1'b1, s.err};
            `A_BHV:  v = {1'b1, 7'h00, s.trig_en};
            default: v = 9'h000;
        endcase
        return v;
    endfunction

    // Write decode with slave ID filtering
    function automatic link_t reg_write(input link_t s, input logic [7:0] a,
                                        input logic [7:0] d);
        link_t r;
        logic  pm_ok;
        r = s;
        pm_ok = (s.sa == s.unique_slave_id) || (s.sa == `BCAST_ID) || (s.sa == s.group_slave_id);
        if (a == `A_PM && pm_ok) begin
            if (d[`PM_PRST]) begin
                r = user_defaults(r);
                r.pm = `PM_RST;
                r.pr_tog = ~s.pr_tog;
            end else begin
                // Trigger bits are strobes and never stored
                r.pm = {d[`PM_MODE], 1'b0, d[`PM_MASK_F], 3'b000};
                if (d[`PM_TRIG0] && d[`PM_MASK0]) begin
                    r.sw_act = s.sw_sh;
                end
            end
        end else if (s.sa == s.unique_slave_id) begin
            case (a)
                `A_SW: begin
                    r.sw_sh = d;
                    if (!s.trig_en) begin
                        r.sw_act = d;
                    end
                end
                `A_MUS: r.unique_slave_id = d[`UNIQUE_SLAVE_ID_F];
                `A_GRP: r.group_slave_id = d[`GROUP_SLAVE_ID_F];
                `A_SWR: begin
                    if (d[`SWR_BIT] && s.v2_b) begin
                        r = user_defaults(r);
                    end
                end
                `A_BHV: r.trig_en = d[`BHV_TEN];
                `A_PID, `A_MID, `A_EPID, `A_REV, `A_ERR: r.err = s.err;
                default: r.err[`E_WR] = 1'b1;
            endcase
        end
        return r;
    endfunction

    // Fetch one read byte and start driving it
    function automatic link_t rd_load(input link_t s);
        link_t      r;
        logic [8:0] v;
        r = s;
        v = reg_read(s, s.addr);
        if (s.addr == `A_ERR) begin
            r.err = `ERR_RST;                                 // Read clears
        end
        if (!v[8]) begin
            r.err[`E_RD] = 1'b1;
        end
        // Drive one edge early so data is stable a full period
        r.sdo = v[7];
        r.rdat = {v[6:0], ~^v[7:0], 1'b0};
        r.oe = 1'b1;
        r.cnt = 4'd0;
        r.ph = PH_RDATA;
        return r;
    endfunction

    // Link-side next state
    always_comb begin
        logic [12:0] f;
        logic [8:0]  fb;
        f = {lq.sh[11:0], i_sdata};
        fb = {lq.sh[7:0], i_sdata};
        ln = lq;
        ln.tg_a = cq.ssc_tog;
        ln.tg_b = lq.tg_a;
        ln.tg_c = lq.tg_b;
        ln.rs_a = i_resetn;
        ln.rs_b = lq.rs_a;
        ln.v2_a = i_proto_v2;
        ln.v2_b = lq.v2_a;
        ln.hist = {lq.hist[0], i_sdata};
        if (!lq.rs_b) begin
            ln = user_defaults(ln);
            ln.ph = PH_IDLE;
            ln.cnt = 4'd0;
            ln.sh = 13'h0000;
            ln.sa = 4'h0;
            ln.rd = 1'b0;
            ln.addr = 8'h00;
            ln.left = 4'h0;
            ln.rdat = 9'h000;
            ln.sdo = 1'b0;
            ln.oe = 1'b0;
            ln.busy = 1'b0;
            ln.pm = `PM_RST;
            ln.err = `ERR_RST;
            ln.unique_slave_id = `UNIQUE_SLAVE_ID_RST;
            ln.group_slave_id = `GROUP_SLAVE_ID_RST;
            ln.pr_tog = 1'b0;
            ln.hold = '{pr_tog: 1'b0, low_power: 1'b1, sw: `SW_RST};
            ln.htog = 1'b0;
        end else begin
            if (lq.tg_b != lq.tg_c) begin
                // Start mark landed; the two earlier bits sit in hist
                if (lq.ph != PH_IDLE) begin
                    ln.err[`E_LEN] = 1'b1;
                end
                ln.ph = PH_CMD;
                ln.sh = {10'h000, lq.hist, i_sdata};
                ln.cnt = 4'd3;
                ln.busy = 1'b1;
                ln.oe = 1'b0;
            end else begin
                unique case (lq.ph)
                    PH_IDLE: ln.busy = 1'b0;
                    PH_CMD: begin
                        ln.sh = f;
                        ln.cnt = lq.cnt + 4'd1;
                        if (lq.cnt == `CMD_LAST) begin
                            ln.cnt = 4'd0;
                            ln.sa = f[12:9];
                            ln.rd = 1'b0;
                            ln.left = 4'h0;
                            if (!(^f)) begin
                                ln.err[`E_CPAR] = 1'b1;
                                ln.ph = PH_IDLE;
                            end else if (f[8]) begin
                                ln = reg_write(ln, `A_SW, {1'b0, f[7:1]});
                                ln.ph = PH_PARK;
                            end else if (f[8:6] == `CMD_REGW) begin
                                ln.addr = {3'b000, f[5:1]};
                                ln.ph = PH_DATA;
                            end else if (f[8:6] == `CMD_REGR) begin
                                ln.addr = {3'b000, f[5:1]};
                                ln.ph = (f[12:9] == lq.unique_slave_id) ? PH_RPARK : PH_IDLE;
                            end else if (f[8:5] == `CMD_EXTW) begin
                                ln.left = f[4:1];
                                ln.ph = PH_ADDR;
                            end else if (f[8:5] == `CMD_EXTR) begin
                                ln.left = f[4:1];
                                ln.rd = 1'b1;
                                ln.ph = PH_ADDR;
                            end else begin
                                ln.ph = PH_IDLE;
                            end
                        end
                    end
                    PH_ADDR: begin
                        ln.sh = f;
                        ln.cnt = lq.cnt + 4'd1;
                        if (lq.cnt == `FRM_LAST) begin
                            ln.cnt = 4'd0;
                            ln.addr = fb[8:1];
                            if (!(^fb)) begin
                                ln.err[`E_APAR] = 1'b1;
                                ln.ph = PH_IDLE;
                            end else if (!lq.rd) begin
                                ln.ph = PH_DATA;
                            end else begin
                                ln.ph = (lq.sa == lq.unique_slave_id) ? PH_RPARK : PH_IDLE;
                            end
                        end
                    end
                    PH_DATA: begin
                        ln.sh = f;
                        ln.cnt = lq.cnt + 4'd1;
                        if (lq.cnt == `FRM_LAST) begin
                            ln.cnt = 4'd0;
                            if (^fb) begin
                                ln = reg_write(ln, lq.addr, fb[8:1]);
                            end else begin
                                ln.err[`E_DPAR] = 1'b1;
                            end
                            ln.addr = lq.addr + 8'd1;
                            ln.left = lq.left - 4'd1;
                            if (lq.left == 4'h0) begin
                                ln.ph = PH_PARK;
                            end
                        end
                    end
                    PH_PARK: begin
                        ln.ph = PH_IDLE;
                        ln.busy = 1'b0;                       // No clock follows the park bit
                    end
                    PH_RPARK: ln = rd_load(ln);
                    PH_RDATA: begin
                        if (lq.cnt == `FRM_LAST) begin
                            if (lq.left == 4'h0) begin
                                ln.oe = 1'b0;
                                ln.sdo = 1'b0;
                                ln.ph = PH_IDLE;
                            end else begin
                                ln.left = lq.left - 4'd1;
                                ln.addr = lq.addr + 8'd1;
                                ln = rd_load(ln);
                            end
                        end else begin
                            ln.sdo = lq.rdat[8];
                            ln.rdat = {lq.rdat[7:0], 1'b0};
                            ln.cnt = lq.cnt + 4'd1;
                        end
                    end
                endcase
            end
            // Publish switch and power word to the core domain on change
            if ({ln.pr_tog, ln.pm[`PM_MODE], ln.sw_act} != lq.hold) begin
                ln.hold = '{pr_tog: ln.pr_tog, low_power: ln.pm[`PM_MODE], sw: ln.sw_act};
                ln.htog = ~lq.htog;
            end
        end
    end

    // Link state register on the bus clock
    always_ff @(negedge i_sclk) begin
        lq <= ln;
    end

    // Core-side next state
    always_comb begin
        cn = cq;
        if (!i_resetn) begin
            cn.sd_a = 1'b0;
            cn.sd_b = 1'b0;
            cn.sd_c = 1'b0;
            cn.bz_a = 1'b0;
            cn.bz_b = 1'b0;
            cn.ht_a = 1'b0;
            cn.ht_b = 1'b0;
            cn.ht_c = 1'b0;
            cn.ssc_tog = 1'b0;
            cn.watch = W_IDLE;
            cn.cur = '{pr_tog: 1'b0, low_power: 1'b1, sw: `SW_RST};
            cn.pr_seen = 1'b0;
            cn.pr_run = 1'b0;
            cn.pst = PS_STARTUP;
        end else if (i_ce) begin
            cn.sd_a = i_sdata;
            cn.sd_b = cq.sd_a;
            cn.sd_c = cq.sd_b;
            cn.bz_a = lq.busy;
            cn.bz_b = cq.bz_a;
            cn.ht_a = lq.htog;
            cn.ht_b = cq.ht_a;
            cn.ht_c = cq.ht_b;
            // Start mark: data rising while the bus is idle
            unique case (cq.watch)
                W_IDLE: begin
                    if (cq.sd_b && !cq.sd_c) begin
                        cn.ssc_tog = ~cq.ssc_tog;
                        cn.watch = W_WAIT;
                    end
                end
                W_WAIT: cn.watch = cq.bz_b ? W_RUN : W_WAIT;
                W_RUN:  cn.watch = cq.bz_b ? W_RUN : W_IDLE;
                default: cn.watch = W_IDLE;
            endcase
            // Hold word is stable once its toggle is seen
            if (cq.ht_b != cq.ht_c) begin
                cn.cur = lq.hold;
            end
            if ((cq.ht_b != cq.ht_c) && (lq.hold.pr_tog != cq.pr_seen)) begin
                cn.pr_seen = lq.hold.pr_tog;
                cn.pr_run = 1'b1;
                cn.pst = PS_STARTUP;
            end else begin
                unique case (cq.pst)
                    PS_STARTUP: begin
                        cn.pst = cq.pr_run ? PS_ACTIVE : PS_LOW;
                        cn.pr_run = 1'b0;
                    end
                    PS_ACTIVE, PS_LOW: cn.pst = cq.cur.low_power ? PS_LOW : PS_ACTIVE;
                    default: cn.pst = PS_STARTUP;
                endcase
            end
        end
    end

    // Core state register
    always_ff @(posedge i_clk) begin
        cq <= cn;
    end

    // Outputs straight from flops
    assign o_power_state = cq.pst;
    assign o_switch_state = cq.cur.sw;
    assign o_sdata = lq.sdo;
    assign o_sdata_oe = lq.oe;

endmodule

//--- test/rffe_switch_asserts.sv
// Purpose: Concurrent checks on the pins of the switch slave
// Assumes: Bus clock stands still between frames
// Notes:   A quiet-bus counter ties output changes to recent bus traffic
`timescale 1ns/1ps
module rffe_switch_checker
    import rffe_switch_pkg::*;
(
    input wire logic                          i_clk,
    input wire logic                          i_resetn,
    input wire logic                          i_ce,
    input wire logic                          i_sclk,
    input wire logic                          i_sdata,
    input wire logic                          i_proto_v2,
    input wire rffe_switch_pkg::power_state_t o_power_state,
    input wire logic [7:0]                    o_switch_state,
    input wire logic                          o_sdata,
    input wire logic                          o_sdata_oe
);
    logic [5:0] idle_r;
    logic       sclk_r;

    // Core cycles since the bus clock last moved, saturating
    always_ff @(posedge i_clk) begin
        sclk_r <= i_sclk;
        if (!i_resetn || sclk_r != i_sclk) begin
            idle_r <= 6'h00;
        end else if (idle_r != 6'h3f) begin
            idle_r <= idle_r + 6'h01;
        end
    end

    // Core domain
    a_boot_low_power: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(i_resetn) |-> o_power_state == PS_STARTUP && o_switch_state == 8'h00
        ##[1:3] o_power_state == PS_LOW) else $error("boot did not reach low power");
    a_boot_not_active: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(i_resetn) |-> (o_power_state != PS_ACTIVE) [*4])
        else $error("active state right after boot");
    a_preset_to_active: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_power_state == PS_STARTUP && $past(o_power_state) != PS_STARTUP
        |-> ##[1:30] o_power_state == PS_ACTIVE) else $error("powered reset skipped active");
    a_preset_to_low: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_power_state == PS_ACTIVE && $past(o_power_state) == PS_STARTUP
        |-> ##[1:30] o_power_state == PS_LOW) else $error("powered reset did not end low");
    a_switch_needs_bus: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $changed(o_switch_state) |-> idle_r < 6'h10) else $error("switch moved on a quiet bus");
    a_wake_needs_bus: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_power_state == PS_ACTIVE && $past(o_power_state) == PS_LOW |-> idle_r < 6'h10)
        else $error("woke up on a quiet bus");
    a_quiet_no_drive: assert property (@(posedge i_clk) disable iff (!i_resetn)
        idle_r == 6'h3f |-> !o_sdata_oe) else $error("data pin driven on a quiet bus");
    a_state_legal: assert property (@(posedge i_clk) disable iff (!i_resetn)
        o_power_state != 2'b10) else $error("illegal power state code");
    // Bus clock domain
    a_read_window: assert property (@(negedge i_sclk) disable iff (!i_resetn)
        $rose(o_sdata_oe) |-> o_sdata_oe [*8]) else $error("read data window cut short");
    a_read_release: assert property (@(negedge i_sclk) disable iff (!i_resetn)
        $rose(o_sdata_oe) |-> ##[8:150] !o_sdata_oe) else $error("data pin never released");
endmodule

bind rffe_switch_control_slave rffe_switch_checker i_rffe_switch_checker (
    .i_clk, .i_resetn, .i_ce, .i_sclk, .i_sdata, .i_proto_v2,
    .o_power_state, .o_switch_state, .o_sdata, .o_sdata_oe
);

//--- test/rffe_bus_master.sv
// Purpose: Behavioural bus master that frames register traffic
// Assumes: Slave samples the data pin on falling clock edges
// Notes:   Clock stands still between frames; a released line shows the inverse level
`timescale 1ns/1ps
module rffe_bus_master (
    output logic      o_sclk,
    output logic      o_line,
    input  wire logic i_sd,
    input  wire logic i_oe
);
    localparam realtime WHP = 3.0;  // Write half period, 6 ns clock
    localparam realtime RHP = 20.0; // Reads at a 40 ns clock
    logic d;
    logic en;

    // Wire level: slave, then master, else inverse of last value
    assign o_line = i_oe ? i_sd : (en ? d : ~d);

    initial begin
        o_sclk = 1'b0;
        d      = 1'b0;
        en     = 1'b1;
    end

    // One clock, data set up ahead of the falling edge
    task automatic tick(input logic b, input realtime hp);
        d = b;
        o_sclk = 1'b1;
        #hp;
        o_sclk = 1'b0;
        #hp;
    endtask

    // Clocks with the line low, no start mark
    task automatic clocks(input int n);
        repeat (n) tick(1'b0, WHP);
    endtask

    // Command, nw bytes out, then nr bytes read back
    task automatic xfer(input logic [3:0] sa, input logic [7:0] cmd, input logic [15:0] w,
                        input int nw, input int nr, input logic bad,
                        output logic [15:0] rd, output logic perr);
        logic [12:0] c;
        logic [8:0]  q;
        int          i;
        int          j;
        rd = 16'h0000;
        perr = 1'b0;
        c = {sa, cmd, ~^{sa, cmd} ^ bad};
        d = 1'b1;
        #25.0;
        d = 1'b0;
        for (i = 12; i >= 0; i--) tick(c[i], WHP);
        for (i = nw; i > 0; i--) begin
            q = {w[8*i-1 -: 8], 1'b0};
            q[0] = ~^q[8:1];
            for (j = 8; j >= 0; j--) tick(q[j], WHP);
        end
        if (nr > 0) begin
            tick(1'b0, RHP);
            en = 1'b0;
            for (i = 0; i < 9 * nr; i++) begin
                o_sclk = 1'b1;
                #RHP;
                q = {q[7:0], o_line};
                if (i % 9 == 8) begin
                    perr = perr | ~^q;
                    rd = {rd[7:0], q[8:1]};
                end
                o_sclk = 1'b0;
                #RHP;
            end
            o_sclk = 1'b1;
            #RHP;
            o_sclk = 1'b0;
            en = 1'b1;
            #RHP;
        end
        tick(1'b0, WHP);
    endtask
endmodule

//--- test/rffe_switch_control_slave_tb_top.sv
// Purpose: Self-checking bench for the switch control slave
// Assumes: Bus master model frames all traffic; core clock 200 MHz
// Notes:   Table rows first, then a mid-run reset by hand
`timescale 1ns/1ps
module rffe_switch_control_slave_tb_top;
    import rffe_switch_pkg::*;
    typedef struct packed {
        logic [3:0]  sa;
        logic [7:0]  cmd;
        logic [15:0] w;
        logic [1:0]  nw;
        logic [1:0]  nr;
        logic        bad;
        logic        v2;
        logic [15:0] rd;
        logic [7:0]  sw;
        logic [1:0]  ps;
    } row_t;
    localparam logic [1:0] LO = 2'b11;
    localparam logic [1:0] AC = 2'b01;
    localparam logic [1:0] NX = 2'b10; // Power state left unchecked
    localparam row_t ROWS [27] = '{
        '{4'h8, 8'h7c, 16'h0000, 2'd0, 2'd1, 1'b0, 1'b1, 16'h0080, 8'h00, LO},
        '{4'h8, 8'h95, 16'h0000, 2'd0, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h00, LO},
        '{4'h8, 8'h5c, 16'h0009, 2'd1, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h15, AC},
        '{4'h8, 8'h7c, 16'h0000, 2'd0, 2'd1, 1'b0, 1'b1, 16'h0008, 8'h15, AC},
        '{4'h8, 8'h60, 16'h0000, 2'd0, 2'd1, 1'b0, 1'b1, 16'h0015, 8'h15, AC},
        '{4'h8, 8'haa, 16'h0000, 2'd0, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h15, AC},
        '{4'h0, 8'hb3, 16'h0000, 2'd0, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h15, AC},
        '{4'h8, 8'h5c, 16'h0001, 2'd1, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h15, AC},
        '{4'h8, 8'h5c, 16'h0008, 2'd1, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h15, AC},
        '{4'h0, 8'h5c, 16'h0009, 2'd1, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h2a, AC},
        '{4'h8, 8'h00, 16'h2b00, 2'd2, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h2a, AC},
        '{4'h8, 8'hc4, 16'h0000, 2'd0, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h44, AC},
        '{4'h8, 8'h21, 16'h002b, 2'd1, 2'd2, 1'b0, 1'b1, 16'h0000, 8'h44, AC},
        '{4'h8, 8'h20, 16'h0024, 2'd1, 2'd1, 1'b0, 1'b1, 16'h0004, 8'h44, AC},
        '{4'h8, 8'h45, 16'h0055, 2'd1, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h44, AC},
        '{4'h8, 8'h20, 16'h0024, 2'd1, 2'd1, 1'b0, 1'b1, 16'h0002, 8'h44, AC},
        '{4'h8, 8'h5c, 16'h0080, 2'd1, 2'd0, 1'b1, 1'b1, 16'h0000, 8'h44, AC},
        '{4'h8, 8'h20, 16'h0024, 2'd1, 2'd1, 1'b0, 1'b1, 16'h0040, 8'h44, AC},
        '{4'h8, 8'h5c, 16'h0040, 2'd1, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h00, LO},
        '{4'h8, 8'h7c, 16'h0000, 2'd0, 2'd1, 1'b0, 1'b1, 16'h0080, 8'h00, LO},
        '{4'h8, 8'h00, 16'h2b01, 2'd2, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h00, LO},
        '{4'h8, 8'h92, 16'h0000, 2'd0, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h00, LO},
        '{4'h8, 8'h5c, 16'h0009, 2'd1, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h12, AC},
        '{4'h8, 8'h00, 16'h2380, 2'd2, 2'd0, 1'b0, 1'b0, 16'h0000, 8'h12, AC},
        '{4'h8, 8'h00, 16'h2380, 2'd2, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h00, AC},
        '{4'h8, 8'h00, 16'h2b00, 2'd2, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h00, AC},
        '{4'h8, 8'hb3, 16'h0000, 2'd0, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h33, AC}
    };
    logic         i_clk, i_resetn, i_ce, i_proto_v2, sclk, line;
    power_state_t o_power_state;
    logic [7:0]   o_switch_state;
    logic         o_sdata, o_sdata_oe;
    int           failures = 0;
    int           n_checks = 0;

    rffe_switch_control_slave i_rffe_switch_control_slave (
        .i_clk, .i_resetn, .i_ce, .i_sclk(sclk), .i_sdata(line), .i_proto_v2,
        .o_power_state, .o_switch_state, .o_sdata, .o_sdata_oe
    );
    rffe_bus_master i_rffe_bus_master (.o_sclk(sclk), .o_line(line), .i_sd(o_sdata),
                                       .i_oe(o_sdata_oe));

    // Core clock, 5 ns
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One frame, then outputs against the row
    task automatic run_row(input row_t r, input int k);
        logic [15:0] rd;
        logic        perr;
        @(posedge i_clk);
        i_proto_v2 <= r.v2;
        repeat (4) @(posedge i_clk);
        i_rffe_bus_master.xfer(r.sa, r.cmd, r.w, int'(r.nw), int'(r.nr), r.bad, rd, perr);
        repeat (40) @(posedge i_clk);
        if (r.nr != 2'd0) begin
            check("read data", rd, r.rd);
            check("read parity", {15'h0000, perr}, 16'h0000);
        end
        check("switch state", {8'h00, o_switch_state}, {8'h00, r.sw});
        if (r.ps != NX) begin
            check("power state", {14'h0000, o_power_state}, {14'h0000, r.ps});
        end
        $display("row %0d done", k);
    endtask

    // Watchdog
    initial begin
        #100000.0;
        failures++;
        $display("watchdog expired");
        close_out();
    end

    // Boot, table rows, mid-run reset
    initial begin
        i_resetn = 1'b0;
        i_ce = 1'b1;
        i_proto_v2 = 1'b1;
        fork
            repeat (20) @(posedge i_clk);
            #10.0 i_rffe_bus_master.clocks(5);
        join
        @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (10) @(posedge i_clk);
        for (int k = 0; k < 27; k++) run_row(ROWS[k], k);
        // Frozen core misses the start mark, so this direct write is lost
        i_ce <= 1'b0;
        run_row('{4'h8, 8'h95, 16'h0000, 2'd0, 2'd0, 1'b0, 1'b1, 16'h0000, 8'h33, AC},
                28);
        i_ce <= 1'b1;
        @(posedge i_clk);
        i_resetn <= 1'b0;
        fork
            repeat (10) @(posedge i_clk);
            i_rffe_bus_master.clocks(5);
        join
        check("reset switch", {8'h00, o_switch_state}, 16'h0000);
        check("reset power", {14'h0000, o_power_state}, {14'h0000, PS_STARTUP});
        @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (10) @(posedge i_clk);
        check("boot power", {14'h0000, o_power_state}, {14'h0000, PS_LOW});
        run_row('{4'h8, 8'h20, 16'h002b, 2'd1, 2'd1, 1'b0, 1'b1, 16'h0001, 8'h00, LO},
                27);
        $display("reset test done");
        close_out();
    end
endmodule
